// [design/acs_sequencer.sv]
// Operation
// RULE1 - Sweep stops when FIFO reaches threshold
// RULE2 - Sweep at threshold: only reads, config accesses; the code also accepts the software power down command here
// RULE3 - Repeat sweep conversion clears FIFO, restarts sequence
// RULE4 - Repeat sweep: reconfigure discards, read then repeat
// RULE5 - Host reads FIFO after threshold fill
// RULE6 - Host selects channel before single/repeat conversions
// RULE7 - Single shot bypasses FIFO; repeat stores results
// RULE8 - Repeat: discard or read, reselect channel
// RULE9 - Short sampling holds twelve serial clocks
// RULE10 - Each conversion triggered by chip select or start
// RULE11 - Sweep results leave in conversion order
// RULE12 - Same sweep reruns without reconfiguring
// RULE13 - Software power down costs an extra command
// RULE14 - Depth, threshold, sequence set by configuration write
`include "acs_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    input  wire logic        conversion_start_pin,
    input  wire logic [11:0] adc_code,
    output var  logic        sampling,
    output var  logic [2:0]  mux_chan,
    output var  logic        busy,
    output var  logic        power_down,
    output var  logic        fifo_hold,
    output var  logic [3:0]  fifo_count,
    output var  logic [11:0] configuration_register,
    output var  acs_result_t result
);

    // Reset and sampling-length crossing into the serial clock domain
    logic [1:0] lrst_sync;
    logic       short_meta;
    logic       short_sync;

    always_ff @(posedge sclk) begin
        lrst_sync  <= {lrst_sync[0], rst_n};
        short_meta <= configuration_register[`ACS_CFG_SHORT_BIT];
        short_sync <= short_meta;
    end

    // Frame-scoped link state; chip select high ends the frame
    acs_link_t ls;
    acs_link_t next_ls;
    acs_hold_t lh;
    acs_hold_t next_lh;
    logic [4:0] samp_end;

    always_comb begin
        next_ls  = ls;
        // Sampling window end depends on the short-sample setting
        samp_end = short_sync ? `ACS_CMD_BITS + `ACS_SHORT_SAMPLE :
                                `ACS_CMD_BITS + `ACS_LONG_SAMPLE; // [RULE9]
        next_ls.shreg = {ls.shreg[14:0], sdi};
        if (ls.cnt != 5'h1F) begin
            next_ls.cnt = ls.cnt + 5'h01;
        end
        // Sampling phase opens after the command nibble
        next_ls.sampling = (next_ls.cnt >= `ACS_CMD_BITS) &&
                           (next_ls.cnt < samp_end); // [RULE9]
    end

    // Chip select high clears the frame state at once
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            ls <= '0;
        end else begin
            ls <= next_ls;
        end
    end

    // Completed frame word and its toggle persist across frames
    always_comb begin
        next_lh = lh;
        if (!cs_n && (ls.cnt == `ACS_FRAME_BITS - 5'h01)) begin
            next_lh.word = {ls.shreg[14:0], sdi};
            next_lh.tog  = ~lh.tog;
        end
    end

    // Word and toggle reset through the synchronised reset
    always_ff @(posedge sclk) begin
        if (!lrst_sync[1]) begin
            lh <= '0;
        end else begin
            lh <= next_lh;
        end
    end

    assign sampling = ls.sampling;

    // Frame toggle and start pin synchronisers in the core domain
    logic tg_meta;
    logic tg_sync;
    logic tg_last;
    logic st_meta;
    logic st_sync;
    logic st_last;

    // Frame toggle: two stages, the third only marks the change
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tg_meta <= 1'b0;
            tg_sync <= 1'b0;
            tg_last <= 1'b0;
        end else begin
            tg_meta <= lh.tog;
            tg_sync <= tg_meta;
            tg_last <= tg_sync;
        end
    end

    // Start pin: idles low, so no false edge follows reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_meta <= 1'b0;
            st_sync <= 1'b0;
            st_last <= 1'b0;
        end else begin
            st_meta <= conversion_start_pin;
            st_sync <= st_meta;
            st_last <= st_sync;
        end
    end

    // Sweep channel order tables
    function automatic logic [2:0] seq_chan(input logic [1:0] sel,
                                            input logic [2:0] idx);
        logic [2:0] c;
        c = idx;
        unique case (sel)
            2'b00: c = idx;
            2'b01: c = {1'b0, idx[1:0]};
            2'b10: c = {1'b1, idx[1:0]};
            // Table 3 converts each of four channels twice
            2'b11: c = {1'b0, idx[2:1]};
        endcase
        return c;
    endfunction

    // Core state and the decoded command fields
    acs_core_t cs;
    acs_core_t next_cs;
    logic        new_cmd;
    logic [3:0]  op;
    logic [11:0] arg;
    logic        pin_trig;
    logic        trig;
    logic        is_cfg_op;
    acs_mode_t   mode;
    logic [3:0]  thr;
    logic [3:0]  fc_next;

    // Decoded frame and pin events
    assign new_cmd  = tg_sync ^ tg_last;
    assign op       = lh.word[15:12];
    assign arg      = lh.word[11:0];
    assign pin_trig = st_sync & ~st_last;
    assign mode     = acs_mode_t'(cs.cfg[`ACS_CFG_MODE_LSB +: 2]);
    assign thr      = 4'h1 << cs.cfg[`ACS_CFG_THR_LSB +: 2];
    assign is_cfg_op = new_cmd && (op == `ACS_CMD_CFG_WR || op == `ACS_CMD_CFG_RD);

    // Conversion trigger from a convert frame or the start pin
    assign trig = pin_trig || (new_cmd && op == `ACS_CMD_CONV); // [RULE10]

    always_comb begin
        next_cs = cs;
        fc_next = cs.fcount;
        next_cs.res.valid = 1'b0;

        // Register accesses and FIFO reads are always accepted
        if (new_cmd) begin
            unique case (op)
                `ACS_CMD_CFG_WR: begin
                    // New settings discard FIFO and channel choice
                    next_cs.cfg     = arg; // [RULE14]
                    next_cs.wp      = 3'h0;
                    next_cs.rp      = 3'h0;
                    fc_next         = 4'h0;
                    next_cs.hold    = 1'b0; // [RULE4] [RULE8]
                    next_cs.chan_ok = 1'b0; // [RULE6]
                    // Sweep index starts over at the first channel
                    next_cs.idx     = 3'h0;
                end
                `ACS_CMD_CFG_RD: begin
                    // Readback of the live settings
                    next_cs.res.valid  = 1'b1;
                    next_cs.res.is_cfg = 1'b1;
                    next_cs.res.chan   = 3'h0;
                    next_cs.res.data   = cs.cfg;
                end
                `ACS_CMD_FIFO_RD: begin
                    // Oldest entry first, so sweep order is kept
                    // Empty FIFO reads give no result
                    if (cs.fcount != 4'h0) begin
                        next_cs.res.valid  = 1'b1;
                        next_cs.res.is_cfg = 1'b0;
                        next_cs.res.chan   = 3'h0;
                        next_cs.res.data   = cs.mem[cs.rp]; // [RULE11]
                        next_cs.rp  = cs.rp + 3'h1;
                        fc_next     = cs.fcount - 4'h1;
                        if (cs.fcount == 4'h1) begin
                            next_cs.hold = 1'b0; // [RULE4] [RULE12] [RULE5]
                        end
                    end
                end
                `ACS_CMD_SEL: begin
                    // Locked out at threshold in FIFO modes
                    if (!cs.hold && cs.state == ACS_IDLE) begin
                        next_cs.chan    = arg[2:0];
                        next_cs.chan_ok = 1'b1; // [RULE6] [RULE8]
                    end
                end
                default: begin
                end
            endcase
        end

        // Software power down needs its own command; anything else wakes
        // A start edge in the same cycle wins; no conversion runs powered down
        if (new_cmd && op == `ACS_CMD_SW_PD && !cs.busy && !pin_trig) begin
            next_cs.swpd = 1'b1; // [RULE13]
        end else if (new_cmd || pin_trig) begin
            next_cs.swpd = 1'b0;
        end

        // Idle waits for a trigger, conv counts the fixed conversion time
        unique case (cs.state)
            ACS_IDLE: begin
                // Triggers racing a settings access are dropped
                if (trig && !is_cfg_op) begin
                    if (cs.hold) begin
                        // Only repeat sweep restarts from a FIFO held at threshold
                        if (mode == ACS_RSWEEP) begin
                            // Counters clear as the first channel starts
                            next_cs.wp       = 3'h0;
                            next_cs.rp       = 3'h0;
                            fc_next          = 4'h0;
                            next_cs.hold     = 1'b0;
                            next_cs.idx      = 3'h1;
                            next_cs.mux_chan = seq_chan(cs.cfg[`ACS_CFG_SEQ_LSB +: 2],
                                                        3'h0); // [RULE3]
                            next_cs.cnt      = 7'h00;
                            next_cs.busy     = 1'b1;
                            next_cs.state    = ACS_CONV;
                        end
                        // Sweep and repeat ignore triggers here [RULE2] [RULE1]
                    end else if (mode == ACS_SINGLE || mode == ACS_REPEAT) begin
                        if (cs.chan_ok) begin
                            next_cs.mux_chan = cs.chan; // [RULE6]
                            next_cs.cnt      = 7'h00;
                            next_cs.busy     = 1'b1;
                            next_cs.state    = ACS_CONV;
                        end
                    end else begin
                        // Sweep modes step through the programmed order
                        next_cs.mux_chan = seq_chan(cs.cfg[`ACS_CFG_SEQ_LSB +: 2],
                                                    cs.idx); // [RULE11]
                        next_cs.idx      = cs.idx + 3'h1;
                        next_cs.cnt      = 7'h00;
                        next_cs.busy     = 1'b1;
                        next_cs.state    = ACS_CONV;
                    end
                end
            end
            ACS_CONV: begin
                // Fixed conversion time counted on the core clock
                if (cs.cnt == 7'(`ACS_CONV_CYCLES - 1)) begin
                    next_cs.busy  = 1'b0;
                    next_cs.state = ACS_IDLE;
                    if (mode == ACS_SINGLE) begin
                        // Result goes straight out, FIFO untouched
                        next_cs.res.valid  = 1'b1;
                        next_cs.res.is_cfg = 1'b0;
                        next_cs.res.chan   = cs.mux_chan;
                        next_cs.res.data   = adc_code; // [RULE7]
                    end else begin
                        next_cs.mem[cs.wp] = adc_code; // [RULE7]
                        next_cs.wp         = cs.wp + 3'h1;
                        fc_next            = fc_next + 4'h1;
                        if (fc_next >= thr) begin
                            // Threshold reached: stop and wait for reads
                            next_cs.hold = 1'b1; // [RULE1]
                            next_cs.idx  = 3'h0; // [RULE12]
                            // Repeat needs a fresh channel choice after a fill
                            if (mode == ACS_REPEAT) begin
                                next_cs.chan_ok = 1'b0; // [RULE8]
                            end
                        end
                    end
                end else begin
                    next_cs.cnt = cs.cnt + 7'h01;
                end
            end
            default: begin
                // Illegal state code falls back to idle
                next_cs.state = ACS_IDLE;
                next_cs.busy  = 1'b0;
            end
        endcase

        // Count carries a push and a pop of the same cycle
        next_cs.fcount = fc_next;
        // Automatic power down needs no extra command
        next_cs.pd = next_cs.swpd ||
                     (cs.cfg[`ACS_CFG_AUTO_BIT] && next_cs.state == ACS_IDLE); // [RULE13]
    end

    // Synchronous reset; settings come up at their reset word
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cs       <= '0;
            cs.state <= ACS_IDLE;
            cs.cfg   <= `ACS_CFG_RESET;
        end else begin
            cs <= next_cs;
        end
    end

    // Outputs straight from the core state
    assign mux_chan               = cs.mux_chan;
    assign busy                   = cs.busy;
    assign power_down             = cs.pd;

    // FIFO status, settings and host results
    assign fifo_hold              = cs.hold;
    assign fifo_count             = cs.fcount;
    assign configuration_register = cs.cfg;
    assign result                 = cs.res;

endmodule

`default_nettype wire

// [design/acs_regs.svh]
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// Command codes, carried in the top nibble of a 16-bit frame
`define ACS_CMD_SEL       4'h1
`define ACS_CMD_CONV      4'h2
`define ACS_CMD_SW_PD     4'h8
`define ACS_CMD_CFG_RD    4'h9
`define ACS_CMD_CFG_WR    4'hA
`define ACS_CMD_FIFO_RD   4'hE

// Configuration word field positions
`define ACS_CFG_MODE_LSB  0
`define ACS_CFG_THR_LSB   2
`define ACS_CFG_SHORT_BIT 4
`define ACS_CFG_AUTO_BIT  5
`define ACS_CFG_SEQ_LSB   6
`define ACS_CFG_RESET     12'h010

// Frame layout and sampling phase lengths in serial clock periods
`define ACS_FRAME_BITS    5'h10
`define ACS_CMD_BITS      5'h04
`define ACS_SHORT_SAMPLE  5'h0C
`define ACS_LONG_SAMPLE   5'h18

// Conversion time and its count at the core clock rate
`define ACS_REF_CLK_MHZ   25
`define ACS_CONV_TIME_NS  3600
`define ACS_CONV_CYCLES   ((`ACS_CONV_TIME_NS * `ACS_REF_CLK_MHZ + 999) / 1000)

`endif

// [design/acs_pkg.sv]
package acs_pkg;

    // Conversion modes as held in the configuration word
    typedef enum logic [1:0] {
        ACS_SINGLE = 2'b00,
        ACS_REPEAT = 2'b01,
        ACS_SWEEP  = 2'b10,
        ACS_RSWEEP = 2'b11
    } acs_mode_t;

    // Core sequencer states
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b01,
        ACS_CONV = 2'b10
    } acs_state_t;

    // Result or readback handed to the host side
    typedef struct packed {
        logic        valid;
        logic        is_cfg;
        logic [2:0]  chan;
        logic [11:0] data;
    } acs_result_t;

    // Frame-scoped link state, cleared while chip select is high
    typedef struct packed {
        logic [4:0]  cnt;
        logic [15:0] shreg;
        logic        sampling;
    } acs_link_t;

    // Link state that survives between frames
    typedef struct packed {
        logic [15:0] word;
        logic        tog;
    } acs_hold_t;

    // Core sequencer state
    typedef struct packed {
        acs_state_t      state;
        logic [11:0]     cfg;
        logic [2:0]      chan;
        logic            chan_ok;
        logic [2:0]      idx;
        logic [6:0]      cnt;
        logic [7:0][11:0] mem;
        logic [2:0]      wp;
        logic [2:0]      rp;
        logic [3:0]      fcount;
        logic            hold;
        logic            swpd;
        logic [2:0]      mux_chan;
        logic            busy;
        logic            pd;
        acs_result_t     res;
    } acs_core_t;

endpackage

// [verif/acs_sequencer_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer_chk
    import acs_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        sampling,
    input wire logic        busy,
    input wire logic        power_down,
    input wire logic        fifo_hold,
    input wire logic [3:0]  fifo_count,
    input wire logic [11:0] configuration_register,
    input wire acs_result_t result
);
    logic [6:0] busy_len;
    logic [4:0] samp_len;
    // Run lengths of busy and of the sampling phase
    always_ff @(posedge ref_clk)
        busy_len <= (busy && rst_n) ? busy_len + 7'h01 : 7'h00;
    always_ff @(posedge sclk)
        samp_len <= sampling ? samp_len + 5'h01 : 5'h00;
    property p_conv_len;
        @(posedge ref_clk) disable iff (!rst_n) $fell(busy) |-> busy_len == 7'h5A;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("bad busy length");
    property p_hold_thr;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(fifo_hold) |-> fifo_count == (4'h1 << configuration_register[3:2]);
    endproperty
    a_hold_thr: assert property (p_hold_thr) else $error("hold off threshold");
    property p_held_idle;
        @(posedge ref_clk) disable iff (!rst_n)
        fifo_hold && !busy && configuration_register[1:0] inside {2'h1, 2'h2} |=> !busy;
    endproperty
    a_held_idle: assert property (p_held_idle) else $error("converted while held");
    property p_restart;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(busy) && $past(fifo_hold) && configuration_register[1:0] == 2'h3
            |-> ##[0:2] fifo_count == 4'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("fifo kept on restart");
    property p_drain;
        @(posedge ref_clk) disable iff (!rst_n) $fell(fifo_hold) |-> fifo_count == 4'h0;
    endproperty
    a_drain: assert property (p_drain) else $error("hold dropped early");
    property p_single;
        @(posedge ref_clk) disable iff (!rst_n)
        configuration_register[1:0] == 2'h0 && $stable(configuration_register)
            |-> fifo_count == 4'h0;
    endproperty
    a_single: assert property (p_single) else $error("single used fifo");
    property p_pd;
        @(posedge ref_clk) disable iff (!rst_n) busy |-> !power_down;
    endproperty
    a_pd: assert property (p_pd) else $error("powered down while busy");
    property p_sample;
        @(posedge sclk) disable iff (!rst_n)
        sampling |-> !cs_n && (!configuration_register[4] || samp_len <= 5'h0C);
    endproperty
    a_sample: assert property (p_sample) else $error("sampling too long");
endmodule
bind acs_sequencer acs_sequencer_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .sclk(sclk), .cs_n(cs_n), .sampling(sampling), .busy(busy), .power_down(power_down),
    .fifo_hold(fifo_hold), .fifo_count(fifo_count), .result(result),
    .configuration_register(configuration_register));
`default_nettype wire

// [verif/acs_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module acs_host_model (
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic sdi,
    input  wire logic sampling
);
    int samp_seen;
    // Link idle: clock low, frame closed
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b1;
        samp_seen = 0;
    end
    // Link clock ticks with no frame open
    task automatic tick(input int n);
        repeat (n) begin
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
    endtask
    // One command frame, MSB first, counting sampling edges
    task automatic frame(input logic [15:0] word);
        samp_seen = 0;
        #7 cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = word[i];
            #80;
            if (sampling === 1'b1)
                samp_seen++;
            sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        sdi = ~sdi; // Data line flipped after the frame closes
        #400;
    endtask
endmodule
`default_nettype wire

// [verif/adc_conversion_mode_sequencer_test.sv]
`include "acs_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_mode_sequencer_test
    import acs_pkg::*;
;
    logic        ref_clk, rst_n, sclk, cs_n, sdi, conversion_start_pin;
    logic        sampling, busy, power_down, fifo_hold;
    logic [2:0]  mux_chan;
    logic [3:0]  fifo_count;
    logic [11:0] adc_code, configuration_register;
    acs_result_t result;
    acs_result_t rq[$];
    int          err_total = 0;
    int          check_count = 0;
    // Core clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    acs_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sampling(sampling));
    acs_sequencer dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .conversion_start_pin(conversion_start_pin), .adc_code(adc_code),
        .sampling(sampling), .mux_chan(mux_chan), .busy(busy), .power_down(power_down),
        .fifo_hold(fifo_hold), .fifo_count(fifo_count), .result(result),
        .configuration_register(configuration_register));
    // Analog input follows the channel; results are collected
    always @(posedge ref_clk) begin
        adc_code <= {9'h140, mux_chan};
        if (result.valid === 1'b1)
            rq.push_back(result);
    end
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic cmd(input logic [3:0] c, input logic [11:0] a);
        host.frame({c, a});
    endtask
    // Trigger one conversion by pin or command, see whether it ran
    task automatic conv(input logic pin, input logic runs);
        logic seen;
        seen = 1'b0;
        if (pin) begin
            @(posedge ref_clk) conversion_start_pin <= 1'b1;
            repeat (3) @(posedge ref_clk);
            conversion_start_pin <= 1'b0;
        end else
            cmd(`ACS_CMD_CONV, 12'h000);
        repeat (130) @(posedge ref_clk) if (busy === 1'b1) seen = 1'b1;
        chk(seen === runs, "conversion start");
    endtask
    task automatic take(input logic c, input logic [2:0] ch, input logic [11:0] d);
        acs_result_t r;
        chk(rq.size() == 1, "result count");
        r = rq.pop_front();
        chk(r.is_cfg === c && r.data === d && (c || r.chan === ch), "result");
    endtask
    task automatic rd(input logic [2:0] ch);
        cmd(`ACS_CMD_FIFO_RD, 12'h000);
        take(1'b0, 3'h0, {9'h140, ch}); // FIFO reads carry no channel tag
    endtask
    task automatic t_single;
        cmd(`ACS_CMD_CFG_WR, 12'h010);
        conv(1'b0, 1'b0);
        cmd(`ACS_CMD_SEL, 12'h005);
        conv(1'b0, 1'b1);
        chk(host.samp_seen == `ACS_SHORT_SAMPLE, "sample length");
        take(1'b0, 3'h5, 12'hA05);
        chk(fifo_count === 4'h0, "single fifo");
    endtask
    task automatic t_repeat;
        cmd(`ACS_CMD_CFG_WR, 12'h015);
        cmd(`ACS_CMD_SEL, 12'h003);
        conv(1'b1, 1'b1);
        conv(1'b1, 1'b1);
        chk(fifo_count === 4'h2 && fifo_hold === 1'b1, "repeat fill");
        conv(1'b0, 1'b0);
        rd(3'h3);
        rd(3'h3);
        conv(1'b0, 1'b0);
        cmd(`ACS_CMD_SEL, 12'h003);
        conv(1'b0, 1'b1);
        cmd(`ACS_CMD_CFG_WR, 12'h015);
        chk(fifo_count === 4'h0, "repeat discard");
    endtask
    task automatic t_sweep;
        cmd(`ACS_CMD_CFG_WR, 12'h09A);
        repeat (4) conv(1'b0, 1'b1);
        chk(fifo_count === 4'h4 && fifo_hold === 1'b1, "sweep fill");
        conv(1'b1, 1'b0);
        cmd(`ACS_CMD_CFG_RD, 12'h000);
        take(1'b1, 3'h0, 12'h09A);
        for (int i = 4; i < 8; i++) rd(3'(i));
        conv(1'b0, 1'b1);
        rd(3'h4);
    endtask
    task automatic t_rsweep;
        cmd(`ACS_CMD_CFG_WR, 12'h053);
        conv(1'b0, 1'b1);
        chk(fifo_hold === 1'b1, "rsweep hold");
        conv(1'b0, 1'b1);
        chk(fifo_count === 4'h1, "rsweep restart");
        rd(3'h0);
        conv(1'b1, 1'b1);
        rd(3'h0);
    endtask
    task automatic t_pd;
        cmd(`ACS_CMD_SW_PD, 12'h000);
        chk(power_down === 1'b1, "soft power down");
        conv(1'b1, 1'b1);
        chk(power_down === 1'b0, "power up");
        cmd(`ACS_CMD_CFG_WR, 12'h030);
        chk(power_down === 1'b1, "auto power down");
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Reset with the link clock running, then the scenarios
    initial begin
        rst_n = 1'b0;
        conversion_start_pin = 1'b0;
        adc_code = 12'h140;
        host.tick(3);
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        host.tick(3);
        chk(configuration_register === `ACS_CFG_RESET && fifo_count === 4'h0, "reset");
        t_single();
        t_repeat();
        t_sweep();
        t_rsweep();
        t_pd();
        complete_run();
    end
    // Watchdog
    initial begin
        #2000000;
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
